// File: aluop_cfg.svh
`ifndef ALUOP_CFG_SVH
`define ALUOP_CFG_SVH

// apb register byte offsets
`define ALUOP_OFS_STATUS     8'h00
`define ALUOP_OFS_RESULT     8'h04
`define ALUOP_OFS_ERROR      8'h08
`define ALUOP_OFS_TARGET     8'h0C
`define ALUOP_OFS_IMPLICIT_ACCUMULATOR_BASE  8'h40
`define ALUOP_OFS_IMPLICIT_ACCUMULATOR_LAST  8'h7C

// status field positions
`define ALUOP_SR_C           0
`define ALUOP_SR_Z           1
`define ALUOP_SR_OV          2
`define ALUOP_SR_N           3
`define ALUOP_SR_DC          4
`define ALUOP_SR_W           5

// error field positions
`define ALUOP_ERR_LIT        0
`define ALUOP_ERR_WIDTH      1
`define ALUOP_ERR_TARGET     2
`define ALUOP_ERR_W          3

// reset values
`define ALUOP_RST_STATUS     5'h00
`define ALUOP_RST_ERROR      3'h0
`define ALUOP_RST_WORD       16'h0000
`define ALUOP_RST_TARGET     23'h000000

// operand limits and steps
`define ALUOP_TEN_BIT_LITERAL_BYTE_MAX 10'h0FF
`define ALUOP_STEP_BYTE      16'h0001
`define ALUOP_STEP_WORD      16'h0002

`endif

// File: aluop_pkg.sv
package aluop_pkg;

  typedef enum logic [2:0] {
    OP_ADD,
    OP_ADD_WITH_CARRY_OP,
    OP_AND,
    OP_ASR,
    OP_ASR_CNT,
    OP_BTST_Z,
    OP_TARGET
  } aluop_op_t;

  typedef enum logic [2:0] {
    FORM_FILE,
    FORM_FILE_ACC,
    FORM_TEN_BIT_LITERAL,
    FORM_REG3,
    FORM_FIVE_BIT_LITERAL,
    FORM_SIGNED_TEN_BIT_LITERAL
  } aluop_form_t;

  typedef enum logic [1:0] {
    WID_WORD,
    WID_BYTE,
    WID_DOUBLE,
    WID_SHADOW
  } aluop_width_t;

  typedef enum logic [2:0] {
    DM_DIRECT,
    DM_INDIRECT,
    DM_POST_INC,
    DM_POST_DEC,
    DM_PRE_INC,
    DM_PRE_DEC,
    DM_OFFSET
  } aluop_dmode_t;

endpackage

// File: aluop_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "aluop_cfg.svh"

module aluop_core
  import aluop_pkg::*;
(
  // operation
  input  wire aluop_op_t                op,
  input  wire logic                     byte_mode,
  input  wire logic [15:0]              a,
  input  wire logic [15:0]              b,
  input  wire logic [3:0]               count,
  input  wire logic [3:0]               bitpos,
  input  wire logic [`ALUOP_SR_W-1:0]   flags_in,
  // answer
  output logic      [15:0]              res,
  output logic      [`ALUOP_SR_W-1:0]   flags_out,
  output logic      [`ALUOP_SR_W-1:0]   upd
);

  logic [16:0]        sum17;
  logic [8:0]         sum9;
  logic [4:0]         sum5;
  logic               cin;
  logic signed [15:0] sw;
  logic signed [7:0]  sb;
  logic               msb;
  logic               is_zero;

  always_comb begin
    cin   = (op == OP_ADD_WITH_CARRY_OP) ? flags_in[`ALUOP_SR_C] : 1'b0;
    sum17 = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    sum9  = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
    sum5  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    sw    = a;
    sb    = a[7:0];
    res   = a;
    flags_out = flags_in;
    upd   = '0;
    case (op)
      OP_ADD, OP_ADD_WITH_CARRY_OP: begin
        res = sum17[15:0];
        upd = 5'h1F;
      end
      OP_AND: begin
        res = a & b;
        upd = (5'h01 << `ALUOP_SR_N) | (5'h01 << `ALUOP_SR_Z);
      end
      OP_ASR: begin
        res = byte_mode ? {a[15:8], a[7], a[7:1]} : {a[15], a[15:1]};
        upd = 5'h1F & ~(5'h01 << `ALUOP_SR_DC);
      end
      OP_ASR_CNT: begin
        res = byte_mode ? {a[15:8], 8'(sb >>> count)} : 16'(sw >>> count);
        upd = (5'h01 << `ALUOP_SR_N) | (5'h01 << `ALUOP_SR_Z);
      end
      OP_BTST_Z: begin
        upd = 5'h01 << `ALUOP_SR_Z;
      end
      default: begin
        upd = '0;
      end
    endcase
    // flags follow the selected width only
    msb     = byte_mode ? res[7] : res[15];
    is_zero = byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);
    flags_out[`ALUOP_SR_N] = msb;
    flags_out[`ALUOP_SR_Z] = is_zero;
    case (op)
      OP_ADD, OP_ADD_WITH_CARRY_OP: begin
        flags_out[`ALUOP_SR_C]  = byte_mode ? sum9[8] : sum17[16];
        flags_out[`ALUOP_SR_DC] = byte_mode ? sum5[4] : sum9[8];
        flags_out[`ALUOP_SR_OV] = byte_mode ? ((a[7] == b[7]) && (res[7] != a[7]))
                                            : ((a[15] == b[15]) && (res[15] != a[15]));
        // sticky zero only ever clears on a carried chain
        if (op == OP_ADD_WITH_CARRY_OP) begin
          flags_out[`ALUOP_SR_Z] = flags_in[`ALUOP_SR_Z] & is_zero;
        end
      end
      OP_ASR: begin
        flags_out[`ALUOP_SR_C]  = a[0];
        flags_out[`ALUOP_SR_OV] = 1'b0;
      end
      OP_BTST_Z: begin
        flags_out[`ALUOP_SR_Z] = ~a[bitpos];
      end
      default: begin
        flags_out[`ALUOP_SR_N] = msb;
      end
    endcase
  end

endmodule

`default_nettype wire

// File: aluop_top.sv
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "aluop_cfg.svh"

// Function
// - add-with-carry sums operands plus carry into accumulator, file or work register
// - keep carry, digit carry, negative, overflow and sticky zero status bits
// - file forms use work register zero as accumulator and choose destination
// - file shift right writes back, updates carry, negative, overflow, zero only
// - file operand field addresses data space 0 up to 0x1FFF
// - ten-bit literal limited to 255 in byte mode, 1023 in word
// - word width by default, byte by suffix; double and shadow distinct
// - short unsigned literal is five bits, 0 to 31
// - bit position field selects bit 0 to 15 of a word
// - base, source, destination fields each select one of sixteen work registers
// - destination: direct, indirect, post/pre inc/dec, and base-plus-register offset
// - 23-bit program address literal must have least significant bit zero
// - signed ten-bit literal is two's complement, -512 to 511
// - shift by count updates only negative and zero

module aluop_top
  import aluop_pkg::*;
#(
  parameter int NUM_IMPLICIT_ACCUMULATOR = 16
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // operation request from the decoder
  input  wire logic                     op_valid,
  input  wire aluop_op_t                op_code,
  input  wire aluop_form_t              op_form,
  input  wire aluop_width_t             op_width,
  input  wire aluop_dmode_t             dest_mode,
  input  wire logic [12:0]              file_addr,
  input  wire logic [15:0]              file_rdata,
  input  wire logic [3:0]               base_work_reg,
  input  wire logic [3:0]               source_work_reg,
  input  wire logic [3:0]               dest_work_reg,
  input  wire logic [9:0]               ten_bit_literal,
  input  wire logic [9:0]               signed_ten_bit_literal,
  input  wire logic [4:0]               five_bit_literal,
  input  wire logic [3:0]               bit_position_field,
  input  wire logic [22:0]              program_addr_literal,
  // data memory write
  output logic                          mem_we,
  output logic      [15:0]              mem_addr,
  output logic      [15:0]              mem_wdata,
  output logic                          mem_byte,
  // completion
  output logic                          op_done,
  output logic                          op_error,
  output logic      [`ALUOP_SR_W-1:0]   status_flags,
  output logic      [22:0]              prog_target
);

  // the index fields are four bits wide, so the file must be exactly sixteen deep
  if (NUM_IMPLICIT_ACCUMULATOR != 16) begin : g_chk
    $error("aluop_top: NUM_IMPLICIT_ACCUMULATOR must be 16");
  end

  logic [15:0]              implicit_accumulator_q [NUM_IMPLICIT_ACCUMULATOR];
  logic [15:0]              implicit_accumulator_d [NUM_IMPLICIT_ACCUMULATOR];
  logic [`ALUOP_SR_W-1:0]   status_q, status_d;
  logic [`ALUOP_ERR_W-1:0]  errsts_q, errsts_d;
  logic [15:0]              result_q, result_d;
  logic [22:0]              target_q, target_d;
  logic                     mem_we_q, mem_we_d;
  logic [15:0]              mem_addr_q, mem_addr_d;
  logic [15:0]              mem_wdata_q, mem_wdata_d;
  logic                     mem_byte_q, mem_byte_d;
  logic                     done_q, done_d;
  logic                     err_q, err_d;
  logic [31:0]              prdata_q, prdata_d;
  logic                     pready_q, pready_d;
  logic                     pslverr_q, pslverr_d;

  logic                     byte_mode;
  logic [15:0]              opa, opb;
  logic [3:0]               shift_cnt;
  logic [15:0]              alu_res;
  logic [`ALUOP_SR_W-1:0]   alu_flags, alu_upd;
  logic [15:0]              step, ptr, wd_val;
  logic [`ALUOP_ERR_W-1:0]  bad;
  logic                     implicit_accumulator_hit, mapped, wr_fire;
  logic [3:0]               implicit_accumulator_idx;

  assign byte_mode = (op_width == WID_BYTE);
  assign wd_val    = implicit_accumulator_q[dest_work_reg];
  assign implicit_accumulator_hit  = (paddr >= `ALUOP_OFS_IMPLICIT_ACCUMULATOR_BASE) && (paddr <= `ALUOP_OFS_IMPLICIT_ACCUMULATOR_LAST)
                     && (paddr[1:0] == 2'b00);
  assign implicit_accumulator_idx  = paddr[5:2];
  assign mapped    = implicit_accumulator_hit || (paddr == `ALUOP_OFS_STATUS) || (paddr == `ALUOP_OFS_RESULT)
                     || (paddr == `ALUOP_OFS_ERROR) || (paddr == `ALUOP_OFS_TARGET);
  assign wr_fire   = psel && penable && pready_q && pwrite;

  // operand selection
  always_comb begin
    opa       = file_rdata;
    opb       = implicit_accumulator_q[0];
    shift_cnt = 4'h0;
    case (op_form)
      FORM_FILE, FORM_FILE_ACC: begin
        opa = file_rdata;
        opb = implicit_accumulator_q[0];
      end
      FORM_TEN_BIT_LITERAL: begin
        opa = {6'h00, ten_bit_literal};
        opb = wd_val;
      end
      FORM_SIGNED_TEN_BIT_LITERAL: begin
        opa = {{6{signed_ten_bit_literal[9]}}, signed_ten_bit_literal};
        opb = wd_val;
      end
      FORM_REG3: begin
        opa       = implicit_accumulator_q[base_work_reg];
        opb       = implicit_accumulator_q[source_work_reg];
        shift_cnt = implicit_accumulator_q[source_work_reg][3:0];
      end
      FORM_FIVE_BIT_LITERAL: begin
        opa       = implicit_accumulator_q[base_work_reg];
        opb       = {11'h000, five_bit_literal};
        shift_cnt = five_bit_literal[3:0];
      end
      default: begin
        opa = file_rdata;
      end
    endcase
  end

  aluop_core u_core (
    .op        (op_code),
    .byte_mode (byte_mode),
    .a         (opa),
    .b         (opb),
    .count     (shift_cnt),
    .bitpos    (bit_position_field),
    .flags_in  (status_q),
    .res       (alu_res),
    .flags_out (alu_flags),
    .upd       (alu_upd)
  );

  // refusal causes
  always_comb begin
    bad = '0;
    bad[`ALUOP_ERR_LIT] = byte_mode && (op_form == FORM_TEN_BIT_LITERAL)
                          && (ten_bit_literal > `ALUOP_TEN_BIT_LITERAL_BYTE_MAX);
    bad[`ALUOP_ERR_WIDTH] = (op_width == WID_DOUBLE) || (op_width == WID_SHADOW);
    bad[`ALUOP_ERR_TARGET] = (op_code == OP_TARGET) && program_addr_literal[0];
  end

  // execution and register file
  always_comb begin
    for (int i = 0; i < NUM_IMPLICIT_ACCUMULATOR; i++) begin
      implicit_accumulator_d[i] = implicit_accumulator_q[i];
    end
    status_d    = status_q;
    errsts_d    = errsts_q;
    result_d    = result_q;
    target_d    = target_q;
    mem_we_d    = 1'b0;
    mem_addr_d  = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    mem_byte_d  = mem_byte_q;
    done_d      = 1'b0;
    err_d       = 1'b0;
    step        = byte_mode ? `ALUOP_STEP_BYTE : `ALUOP_STEP_WORD;
    ptr         = wd_val;
    // software writes first so that a same-cycle hardware update wins
    if (wr_fire) begin
      if (paddr == `ALUOP_OFS_STATUS) begin
        status_d = pwdata[`ALUOP_SR_W-1:0];
      end
      if (paddr == `ALUOP_OFS_ERROR) begin
        errsts_d = errsts_q & ~pwdata[`ALUOP_ERR_W-1:0];
      end
      if (implicit_accumulator_hit) begin
        implicit_accumulator_d[implicit_accumulator_idx] = pwdata[15:0];
      end
    end
    if (op_valid) begin
      if (bad != '0) begin
        err_d    = 1'b1;
        errsts_d = errsts_d | bad;
      end else begin
        done_d   = 1'b1;
        status_d = (status_d & ~alu_upd) | (alu_flags & alu_upd);
        if (op_code == OP_TARGET) begin
          target_d = program_addr_literal;
        end else if (op_code != OP_BTST_Z) begin
          result_d = alu_res;
          if (op_form == FORM_FILE) begin
            mem_we_d    = 1'b1;
            mem_addr_d  = {3'b000, file_addr};
            mem_wdata_d = alu_res;
            mem_byte_d  = byte_mode;
          end else if (op_form == FORM_FILE_ACC) begin
            implicit_accumulator_d[0] = byte_mode ? {implicit_accumulator_q[0][15:8], alu_res[7:0]} : alu_res;
          end else if (dest_mode == DM_DIRECT) begin
            implicit_accumulator_d[dest_work_reg] = byte_mode ? {wd_val[15:8], alu_res[7:0]} : alu_res;
          end else begin
            // indirect destinations go to data memory
            case (dest_mode)
              DM_PRE_INC: begin
                ptr                   = wd_val + step;
                implicit_accumulator_d[dest_work_reg] = ptr;
              end
              DM_PRE_DEC: begin
                ptr                   = wd_val - step;
                implicit_accumulator_d[dest_work_reg] = ptr;
              end
              DM_POST_INC: begin
                implicit_accumulator_d[dest_work_reg] = wd_val + step;
              end
              DM_POST_DEC: begin
                implicit_accumulator_d[dest_work_reg] = wd_val - step;
              end
              DM_OFFSET: begin
                ptr = wd_val + implicit_accumulator_q[base_work_reg];
              end
              default: begin
                ptr = wd_val;
              end
            endcase
            mem_we_d    = 1'b1;
            mem_addr_d  = ptr;
            mem_wdata_d = alu_res;
            mem_byte_d  = byte_mode;
          end
        end
      end
    end
  end

  // apb slave, one wait state
  always_comb begin
    pready_d  = psel && penable && !pready_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (psel && penable && !pready_q) begin
      pslverr_d = !mapped;
      prdata_d  = 32'h00000000;
      if (implicit_accumulator_hit) begin
        prdata_d = {16'h0000, implicit_accumulator_q[implicit_accumulator_idx]};
      end else begin
        case (paddr)
          `ALUOP_OFS_STATUS: prdata_d = {27'h0000000, status_q};
          `ALUOP_OFS_RESULT: prdata_d = {16'h0000, result_q};
          `ALUOP_OFS_ERROR:  prdata_d = {29'h00000000, errsts_q};
          `ALUOP_OFS_TARGET: prdata_d = {9'h000, target_q};
          default:           prdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_IMPLICIT_ACCUMULATOR; i++) begin
        implicit_accumulator_q[i] <= `ALUOP_RST_WORD;
      end
      status_q    <= `ALUOP_RST_STATUS;
      errsts_q    <= `ALUOP_RST_ERROR;
      result_q    <= `ALUOP_RST_WORD;
      target_q    <= `ALUOP_RST_TARGET;
      mem_we_q    <= 1'b0;
      mem_addr_q  <= `ALUOP_RST_WORD;
      mem_wdata_q <= `ALUOP_RST_WORD;
      mem_byte_q  <= 1'b0;
      done_q      <= 1'b0;
      err_q       <= 1'b0;
      prdata_q    <= 32'h00000000;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_IMPLICIT_ACCUMULATOR; i++) begin
        implicit_accumulator_q[i] <= implicit_accumulator_d[i];
      end
      status_q    <= status_d;
      errsts_q    <= errsts_d;
      result_q    <= result_d;
      target_q    <= target_d;
      mem_we_q    <= mem_we_d;
      mem_addr_q  <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      mem_byte_q  <= mem_byte_d;
      done_q      <= done_d;
      err_q       <= err_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign mem_we       = mem_we_q;
  assign mem_addr     = mem_addr_q;
  assign mem_wdata    = mem_wdata_q;
  assign mem_byte     = mem_byte_q;
  assign op_done      = done_q;
  assign op_error     = err_q;
  assign status_flags = status_q;
  assign prog_target  = target_q;

endmodule

`default_nettype wire

// File: aluop_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "aluop_cfg.svh"
module aluop_top_properties
  import aluop_pkg::*;
(
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // operation
  input wire logic                   op_valid,
  input wire aluop_op_t              op_code,
  input wire aluop_form_t            op_form,
  input wire aluop_width_t           op_width,
  input wire logic [9:0]             ten_bit_literal,
  input wire logic [22:0]            program_addr_literal,
  // answer
  input wire logic                   op_done,
  input wire logic                   op_error,
  input wire logic [`ALUOP_SR_W-1:0] status_flags,
  input wire logic [22:0]            prog_target
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ok_w;
  // a status write may land on the same edge, so those cycles are skipped
  assign ok_w = (op_width == WID_WORD || op_width == WID_BYTE) && !pready;

  one_answer_a: assert property (op_valid |=> op_done != op_error)
    else $error("op answer missing or doubled");
  answer_cause_a: assert property (op_done || op_error |-> $past(op_valid))
    else $error("op answer without request");
  wide_refused_a: assert property (op_valid && op_width inside {WID_DOUBLE, WID_SHADOW}
    |=> op_error) else $error("double or shadow width accepted");
  byte_lit_a: assert property (op_valid && op_form == FORM_TEN_BIT_LITERAL && op_width == WID_BYTE
    && ten_bit_literal > 10'h0FF |=> op_error) else $error("wide byte literal accepted");
  word_ok_a: assert property (op_valid && op_code inside {OP_ADD, OP_ADD_WITH_CARRY_OP, OP_AND}
    && op_form inside {FORM_TEN_BIT_LITERAL, FORM_REG3} && op_width == WID_WORD |=> op_done)
    else $error("word operation refused");
  target_lsb_a: assert property (op_valid && op_code == OP_TARGET && program_addr_literal[0]
    |=> op_error && $stable(prog_target)) else $error("odd target accepted");
  target_store_a: assert property (op_valid && op_code == OP_TARGET && op_width == WID_WORD
    && !program_addr_literal[0] |=> prog_target == $past(program_addr_literal))
    else $error("target not stored");
  cnt_keeps_a: assert property (op_valid && op_code == OP_ASR_CNT && ok_w
    |=> $stable(status_flags[`ALUOP_SR_C]) && $stable(status_flags[`ALUOP_SR_OV]))
    else $error("count shift touched carry or overflow");
  and_keeps_a: assert property (op_valid && op_code == OP_AND && ok_w
    |=> $stable({status_flags[`ALUOP_SR_C], status_flags[`ALUOP_SR_OV],
    status_flags[`ALUOP_SR_DC]})) else $error("and touched carry flags");
  apb_wait_a: assert property (psel && !penable ##1 psel && penable |=> pready)
    else $error("apb answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held over two cycles");

  cover property (op_valid ##1 op_done);
  cover property (op_valid ##1 op_error);
  cover property (pready && pslverr);
endmodule

bind aluop_top aluop_top_properties i_aluop_top_properties (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .op_valid, .op_code, .op_form,
  .op_width, .ten_bit_literal, .program_addr_literal, .op_done, .op_error, .status_flags,
  .prog_target
);
`default_nettype wire

// File: aluop_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module aluop_mem_model (
  // clock
  input  wire logic        pclk,
  // file register read
  input  wire logic [12:0] file_addr,
  output logic      [15:0] file_rdata,
  // data memory write
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        mem_byte
);
  logic [15:0] mem_q [0:8191];
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem_q[i] = ~16'(i);
    end
  end
  // whole direct range answers in the same cycle
  assign file_rdata = mem_q[file_addr];
  // byte writes carry the byte in the low half of the data
  always @(posedge pclk) begin
    if (mem_we && !mem_byte) mem_q[mem_addr[13:1]] <= mem_wdata;
    else if (mem_we && mem_addr[0]) mem_q[mem_addr[13:1]][15:8] <= mem_wdata[7:0];
    else if (mem_we) mem_q[mem_addr[13:1]][7:0] <= mem_wdata[7:0];
  end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aluop_cfg.svh"
module tb_top
  import aluop_pkg::*;
;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, op_valid = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, prdata;
  logic         pready, pslverr, mem_we, mem_byte, op_done, op_error;
  logic [15:0]  mem_addr, mem_wdata, file_rdata, x, y;
  logic [4:0]   status_flags, f;
  logic [22:0]  prog_target, program_addr_literal = 23'h0;
  aluop_op_t    op_code = OP_ADD;
  aluop_form_t  op_form = FORM_REG3;
  aluop_width_t op_width = WID_WORD;
  aluop_dmode_t dest_mode = DM_DIRECT;
  logic [12:0]  file_addr = 13'h0;
  logic [3:0]   base_work_reg = 4'h1, source_work_reg = 4'h2, dest_work_reg = 4'h3;
  logic [9:0]   ten_bit_literal = 10'h0, signed_ten_bit_literal = 10'h0;
  logic [4:0]   five_bit_literal = 5'h0;
  logic [3:0]   bit_position_field = 4'h0;
  logic [20:0]  e;
  logic [32:0]  bus_q[$];
  logic [32:0]  wr_q[$];
  logic [1:0]   op_q[$];
  int           mismatches = 0;
  int           n_compared = 0;
  integer       seed = 56;

  always #50 pclk = ~pclk;

  aluop_top i_aluop_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .op_valid, .op_code, .op_form, .op_width, .dest_mode, .file_addr,
    .file_rdata, .base_work_reg, .source_work_reg, .dest_work_reg, .ten_bit_literal,
    .signed_ten_bit_literal, .five_bit_literal, .bit_position_field,
    .program_addr_literal, .mem_we, .mem_addr, .mem_wdata, .mem_byte, .op_done,
    .op_error, .status_flags, .prog_target
  );
  aluop_mem_model i_aluop_mem_model (
    .pclk, .file_addr, .file_rdata, .mem_we, .mem_addr, .mem_wdata, .mem_byte
  );

  task automatic cmp(input string what, input logic [32:0] ex, input logic [32:0] got);
    n_compared++;
    if (got !== ex) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] wa(input logic [3:0] i);
    return `ALUOP_OFS_IMPLICIT_ACCUMULATOR_BASE + {2'b00, i, 2'b00};
  endfunction

  function automatic logic [20:0] addf(input logic [15:0] a, b, input logic ci, zin);
    logic [16:0] s;
    logic [4:0]  g;
    s = a + b + ci;
    g = 5'h00;
    g[`ALUOP_SR_C] = s[16];
    g[`ALUOP_SR_Z] = zin && s[15:0] == 16'h0000;
    g[`ALUOP_SR_OV] = a[15] == b[15] && s[15] != a[15];
    g[`ALUOP_SR_N] = s[15];
    g[`ALUOP_SR_DC] = ({1'b0, a[7:0]} + b[7:0] + ci) > 9'h0FF;
    return {g, s[15:0]};
  endfunction

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready read right after the edge is the value sampled at that edge
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 40);
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 40) cmp("pready", 33'h1, 33'h0);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [32:0] ex);
    bus_q.push_back(ex);
    apb(1'b0, ad, 32'h0);
  endtask

  task automatic op(input aluop_op_t c, input aluop_form_t fm, input aluop_width_t w,
                    input logic [22:0] l, input logic err);
    op_q.push_back({!err, err});
    @(posedge pclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_form <= fm;
    op_width <= w;
    ten_bit_literal <= l[9:0];
    signed_ten_bit_literal <= l[9:0];
    five_bit_literal <= l[4:0];
    bit_position_field <= l[3:0];
    file_addr <= l[12:0];
    program_addr_literal <= l;
    @(posedge pclk);
    op_valid <= 1'b0;
  endtask

  // results are settled by the falling edge
  always @(negedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1)
      cmp("prdata", bus_q.pop_front(), {pslverr, prdata});
    if (op_done === 1'b1 || op_error === 1'b1)
      cmp("op answer", {31'h0, op_q.pop_front()}, {31'h0, op_done, op_error});
    if (mem_we === 1'b1)
      cmp("mem write", wr_q.pop_front(), {1'b0, mem_addr, mem_wdata});
  end

  initial begin
    #3_000_000;
    cmp("timeout", 33'h0, 33'h1);
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ALUOP_OFS_STATUS, 33'h0);
    $display("test reset done");
    for (int k = 0; k < 14; k++) begin
      x = 16'($random(seed));
      y = 16'($random(seed));
      apb(1'b1, wa(4'h1), {16'h0, x});
      apb(1'b1, wa(4'h2), {16'h0, y});
      apb(1'b1, `ALUOP_OFS_STATUS, (k < 8) ? {30'h0, 2'(k)} : 32'h15);
      e = addf(x, y, k[2] & k[0], k[2] ? k[1] : 1'b1);
      f = 5'h15;
      case (k % 3)
        0: e[15:0] = x & y;
        1: e[15:0] = $signed(x) >>> 1;
        default: e[15:0] = $signed(x) >>> y[3:0];
      endcase
      f[`ALUOP_SR_C] = (k % 3 == 1) ? x[0] : 1'b1;
      f[`ALUOP_SR_OV] = (k % 3 != 1);
      f[`ALUOP_SR_N] = e[15];
      f[`ALUOP_SR_Z] = e[15:0] == 16'h0000;
      if (k < 8) e = addf(x, y, k[2] & k[0], k[2] ? k[1] : 1'b1);
      else e[20:16] = f;
      if (k < 8) op(k[2] ? OP_ADD_WITH_CARRY_OP : OP_ADD, FORM_REG3, WID_WORD, 23'h0, 1'b0);
      else op(k % 3 == 0 ? OP_AND : k % 3 == 1 ? OP_ASR : OP_ASR_CNT, FORM_REG3,
              WID_WORD, 23'h0, 1'b0);
      rd(wa(4'h3), {17'h0, e[15:0]});
      rd(`ALUOP_OFS_STATUS, {28'h0, e[20:16]});
    end
    $display("test arithmetic done");
    e = addf(x, 16'h001F, 1'b0, 1'b1);
    op(OP_ADD, FORM_FIVE_BIT_LITERAL, WID_WORD, 23'h1F, 1'b0);
    rd(wa(4'h3), {17'h0, e[15:0]});
    apb(1'b1, wa(4'h0), {16'h0, y});
    e = addf(16'hE000, y, 1'b0, 1'b1);
    op(OP_ADD, FORM_FILE_ACC, WID_WORD, 23'h1FFF, 1'b0);
    rd(wa(4'h0), {17'h0, e[15:0]});
    // file word 0x0010 holds 0xFFEF in the model; shifted back it reads 0xFFF7
    wr_q.push_back({1'b0, 16'h0010, 16'hFFF7});
    op(OP_ASR, FORM_FILE, WID_WORD, 23'h0010, 1'b0);
    $display("test operand forms done");
    op(OP_ADD, FORM_TEN_BIT_LITERAL, WID_BYTE, 23'h0FF, 1'b0);
    op(OP_ADD, FORM_TEN_BIT_LITERAL, WID_BYTE, 23'h100, 1'b1);
    op(OP_ADD, FORM_TEN_BIT_LITERAL, WID_WORD, 23'h3FF, 1'b0);
    op(OP_ADD, FORM_REG3, WID_DOUBLE, 23'h0, 1'b1);
    op(OP_ADD, FORM_REG3, WID_SHADOW, 23'h0, 1'b1);
    op(OP_TARGET, FORM_REG3, WID_WORD, 23'h7FFFFE, 1'b0);
    op(OP_TARGET, FORM_REG3, WID_WORD, 23'h000003, 1'b1);
    rd(`ALUOP_OFS_TARGET, {10'h0, 23'h7FFFFE});
    rd(`ALUOP_OFS_ERROR, 33'h7);
    rd(8'h10, {1'b1, 32'h0});
    $display("test refusals done");
    end_of_test();
  end
endmodule
`default_nettype wire
